// file: hdl/isa_sideband_pkg.sv
package isa_sideband_pkg;
  // fixed pin widths of the multiplexed sideband
  localparam int IRQ_PINS = 4;
  localparam int DREQ_PINS = 2;
  localparam int MUX_PHASES = 4;
  localparam int IRQ_CHANS = IRQ_PINS * MUX_PHASES;
  localparam int DREQ_CHANS = DREQ_PINS * MUX_PHASES;
  // irq channel that carries the rtc's active-low request
  localparam int RTC_IRQ_CHAN = 8;
  // i/o ports decoded on the isa side
  localparam logic [15:0] RTC_ADDR_PORT = 16'h0070;
  localparam logic [15:0] RTC_DATA_PORT = 16'h0071;
  localparam logic [15:0] KBD_DATA_PORT = 16'h0060;
  localparam logic [15:0] KBD_CMD_PORT = 16'h0064;
  localparam logic [15:0] GP_LATCH_PORT = 16'h00e0;
  // boot rom window in the first megabyte
  localparam logic [19:0] ROM_BASE = 20'he0000;
  localparam logic [19:0] ROM_MASK = 20'he0000;
  // dma acknowledge code shown when no channel is acknowledged
  localparam logic [2:0] DACK_IDLE_CODE = 3'h4;
  // core cycles per doubled isa clock half period on the pci path (pciclk/4 at about 33 MHz)
  localparam int PCI_TICK_DIV = 3;
  // reset values
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic STROBE_N_RST = 1'b1;
endpackage : isa_sideband_pkg

// file: hdl/mux_phase_if.sv
`timescale 1ns/1ps
interface mux_phase_if;
  import isa_sideband_pkg::*;
  logic [1:0] phase;
  logic tick;
  logic [IRQ_CHANS-1:0] irq_vec;
  logic [DREQ_CHANS-1:0] dreq_vec;
  modport src (output phase, output tick, output irq_vec, output dreq_vec);
  modport snk (input phase, input tick, input irq_vec, input dreq_vec);
endinterface : mux_phase_if

// file: hdl/isa_mux_phase.sv
`timescale 1ns/1ps
module isa_mux_phase
  import isa_sideband_pkg::*;
#(
  parameter int TICK_DIV = PCI_TICK_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src_osc,
  input wire logic osc14m_pin,
  input wire logic [IRQ_PINS-1:0] irq_pin,
  input wire logic [DREQ_PINS-1:0] dreq_pin,
  mux_phase_if.src mp
);
  // the capture three cycles after a tick must land no later than the next tick, and div_q is 8 bits
  if (TICK_DIV < 3 || TICK_DIV > 256) begin : g_bad_div
    $error("TICK_DIV must lie between 3 and 256");
  end

  logic [IRQ_PINS-1:0] irq_s1_q, irq_s2_q;
  logic [DREQ_PINS-1:0] dreq_s1_q, dreq_s2_q;
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [7:0] div_q;
  logic [1:0] phase_q;
  logic tick_q;
  logic [1:0] cap_pipe_q;
  logic [IRQ_CHANS-1:0] irq_q;
  logic [DREQ_CHANS-1:0] dreq_q;
  wire div_end = (div_q == 8'(TICK_DIV - 1));
  wire osc_edge = (osc_s2_q != osc_s3_q);
  wire tick_d = src_osc ? osc_edge : div_end;
  // pins seen at capture time still belong to the phase before the current one
  wire [1:0] cap_slot = phase_q - 2'h1;

  // pin synchronisers, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      dreq_s1_q <= '0;
      dreq_s2_q <= '0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_pin;
      irq_s2_q <= irq_s1_q;
      dreq_s1_q <= dreq_pin;
      dreq_s2_q <= dreq_s1_q;
      osc_s1_q <= osc14m_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) div_q <= '0;
    else if (div_end || src_osc) div_q <= '0;
    else div_q <= div_q + 8'h01;
  end

  // phase step and per-phase capture
  // a group reaches the second sync stage three cycles after its phase starts (output flop plus
  // two sync flops), so it is taken three cycles after the tick, just as its phase ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PHASE_RST;
      tick_q <= 1'b0;
      cap_pipe_q <= 2'h0;
      irq_q <= '0;
      dreq_q <= '0;
    end else begin
      tick_q <= tick_d;
      cap_pipe_q <= {cap_pipe_q[0], tick_q};
      if (tick_d) phase_q <= phase_q + 2'h1;
      if (cap_pipe_q[1]) begin
        irq_q[cap_slot*IRQ_PINS +: IRQ_PINS] <= irq_s2_q;
        dreq_q[cap_slot*DREQ_PINS +: DREQ_PINS] <= dreq_s2_q;
      end
    end
  end

  // phase bit 1 is the isa clock, bit 0 its double
  assign mp.phase = phase_q;
  assign mp.tick = tick_q;
  assign mp.irq_vec = irq_q;
  assign mp.dreq_vec = dreq_q;

  property p_phase_step;
    @(posedge clk) disable iff (!rst_n) tick_d |=> phase_q == $past(phase_q) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");
endmodule : isa_mux_phase

// file: hdl/isa_sideband_decode.sv
`timescale 1ns/1ps
// Summary of operation
// - io write to latch port pulls latch strobe so SD[7:0] gets latched.
// - irq channel 8 is inverted so the rtc's active-low pin wires straight.
// - dma acknowledge leaves as a 3-bit code; outside logic decodes it.
// - final transfer flag is driven during the last dma transfer.
// - io write to port 70h asserts the rtc address strobe.
// - io write to port 71h asserts the rtc read/write strobe.
// - io read of port 71h asserts the rtc data strobe.
// - memory cycle hitting rom asserts the shared rom/rtc select.
// - io cycle hitting the rtc asserts the same shared select.
// - io cycle hitting the keyboard ports asserts the keyboard select.
// - rom/rtc select, keyboard select, rtc rw and data strobe pins carry isa function only while isa owns the pins.
// - ownership control low picks isa, high picks ide on shared pins.
// - isa clock is pci clock over four or 14.318 MHz over two.
module isa_sideband_decode
  import isa_sideband_pkg::*;
#(
  parameter int TICK_DIV = PCI_TICK_DIV
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CLK_SRC_OSC,
  input wire logic OSC14M_IN,
  input wire logic [IRQ_PINS-1:0] MUXED_IRQ_IN,
  input wire logic [DREQ_PINS-1:0] MUXED_DMA_REQ_IN,
  input wire logic CYC_IO_WR,
  input wire logic CYC_IO_RD,
  input wire logic CYC_MEM,
  input wire logic [19:0] CYC_ADDR,
  input wire logic DMA_ACK_ACTIVE,
  input wire logic [2:0] DMA_ACK_CHAN,
  input wire logic DMA_LAST_XFER,
  input wire logic ISA_BUS_OWN,
  input wire logic [15:12] IDE_DD_OUT,
  output logic ISA_BUS_CLK,
  output logic ISA_BUS_CLK_DOUBLE,
  output logic [IRQ_CHANS-1:0] IRQ_REQ,
  output logic [DREQ_CHANS-1:0] DMA_REQ,
  output logic [2:0] ENCODED_DMA_ACK_OUT,
  output logic DMA_FINAL_TRANSFER,
  output logic GP_LATCH_STROBE_N,
  output logic RTC_ADDR_STROBE_N,
  output logic ROM_RTC_SELECT_N,
  output logic KBD_SELECT_N,
  output logic RTC_RW_STROBE_N,
  output logic RTC_DATA_STROBE,
  output logic ISA_OWNER_OE_N
);
  mux_phase_if mp ();

  isa_mux_phase #(.TICK_DIV(TICK_DIV)) u_phase (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .src_osc(CLK_SRC_OSC),
    .osc14m_pin(OSC14M_IN),
    .irq_pin(MUXED_IRQ_IN),
    .dreq_pin(MUXED_DMA_REQ_IN),
    .mp(mp.src)
  );

  function automatic logic io_hit(input logic [19:0] addr, input logic [15:0] port);
    io_hit = (addr[15:0] == port);
  endfunction : io_hit

  // address decode of the current isa cycle
  wire io_cyc = CYC_IO_WR | CYC_IO_RD;
  wire rtc_io = io_hit(CYC_ADDR, RTC_ADDR_PORT) | io_hit(CYC_ADDR, RTC_DATA_PORT);
  wire kbd_io = io_hit(CYC_ADDR, KBD_DATA_PORT) | io_hit(CYC_ADDR, KBD_CMD_PORT);
  wire rom_mem = CYC_MEM & ((CYC_ADDR & ROM_MASK) == ROM_BASE);
  wire gp_hit = CYC_IO_WR & io_hit(CYC_ADDR, GP_LATCH_PORT);
  wire rtc_as_hit = CYC_IO_WR & io_hit(CYC_ADDR, RTC_ADDR_PORT);
  wire rtc_rw_hit = CYC_IO_WR & io_hit(CYC_ADDR, RTC_DATA_PORT);
  wire rtc_ds_hit = CYC_IO_RD & io_hit(CYC_ADDR, RTC_DATA_PORT);
  wire romrtc_hit = rom_mem | (io_cyc & rtc_io);
  wire kbd_hit = io_cyc & kbd_io;

  // shared pins: isa strobes while isa owns them, ide data bits otherwise
  // ownership gates shared pins
  wire romrtc_pin = ISA_BUS_OWN ? ~romrtc_hit : IDE_DD_OUT[15];
  wire kbd_pin = ISA_BUS_OWN ? ~kbd_hit : IDE_DD_OUT[14];
  wire rw_pin = ISA_BUS_OWN ? ~rtc_rw_hit : IDE_DD_OUT[13];
  wire ds_pin = ISA_BUS_OWN ? rtc_ds_hit : IDE_DD_OUT[12];

  // acknowledge code: channel while active, idle code otherwise
  wire [2:0] dack_code = DMA_ACK_ACTIVE ? DMA_ACK_CHAN : DACK_IDLE_CODE;
  wire [IRQ_CHANS-1:0] irq_fixed = mp.irq_vec ^ (IRQ_CHANS'(1) << RTC_IRQ_CHAN);

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      GP_LATCH_STROBE_N <= STROBE_N_RST;
      RTC_ADDR_STROBE_N <= STROBE_N_RST;
      ROM_RTC_SELECT_N <= STROBE_N_RST;
      KBD_SELECT_N <= STROBE_N_RST;
      RTC_RW_STROBE_N <= STROBE_N_RST;
      RTC_DATA_STROBE <= 1'b0;
      ISA_OWNER_OE_N <= 1'b1;
    end else begin
      GP_LATCH_STROBE_N <= ~gp_hit;
      RTC_ADDR_STROBE_N <= ~rtc_as_hit;
      ROM_RTC_SELECT_N <= romrtc_pin;
      KBD_SELECT_N <= kbd_pin;
      RTC_RW_STROBE_N <= rw_pin;
      RTC_DATA_STROBE <= ds_pin;
      ISA_OWNER_OE_N <= ~ISA_BUS_OWN;
    end
  end

  // rtc irq inversion, plus demultiplexed requests
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      IRQ_REQ <= '0;
      DMA_REQ <= '0;
    end else begin
      IRQ_REQ <= irq_fixed;
      DMA_REQ <= mp.dreq_vec;
    end
  end

  // ack code moves only with the phase so decoders never glitch
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ENCODED_DMA_ACK_OUT <= DACK_IDLE_CODE;
      DMA_FINAL_TRANSFER <= 1'b0;
    end else begin
      if (mp.tick) ENCODED_DMA_ACK_OUT <= dack_code;
      DMA_FINAL_TRANSFER <= DMA_ACK_ACTIVE & DMA_LAST_XFER;
    end
  end

  // isa clock pair straight from the phase flops
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ISA_BUS_CLK <= 1'b0;
      ISA_BUS_CLK_DOUBLE <= 1'b0;
    end else begin
      ISA_BUS_CLK <= mp.phase[1];
      ISA_BUS_CLK_DOUBLE <= mp.phase[0];
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  property p_gp_latch;
    gp_hit |=> !GP_LATCH_STROBE_N;
  endproperty
  a_gp_latch: assert property (p_gp_latch) else $error("latch strobe missing");
  property p_rtc_irq_inv;
    ##1 1'b1 |-> IRQ_REQ[RTC_IRQ_CHAN] == !$past(mp.irq_vec[RTC_IRQ_CHAN]);
  endproperty
  a_rtc_irq_inv: assert property (p_rtc_irq_inv) else $error("rtc irq not inverted");
  property p_final_xfer;
    (DMA_ACK_ACTIVE && DMA_LAST_XFER) |=>
      DMA_FINAL_TRANSFER ##1 (DMA_FINAL_TRANSFER == $past(DMA_ACK_ACTIVE && DMA_LAST_XFER));
  endproperty
  a_final_xfer: assert property (p_final_xfer) else $error("final transfer flag wrong");
  property p_final_clear;
    !(DMA_ACK_ACTIVE && DMA_LAST_XFER) |=> !DMA_FINAL_TRANSFER;
  endproperty
  a_final_clear: assert property (p_final_clear) else $error("final transfer flag stuck");
  property p_rtc_as;
    (CYC_IO_WR && CYC_ADDR[15:0] == RTC_ADDR_PORT) |=> !RTC_ADDR_STROBE_N;
  endproperty
  a_rtc_as: assert property (p_rtc_as) else $error("rtc address strobe missing");
  property p_rtc_rw;
    (ISA_BUS_OWN && CYC_IO_WR && CYC_ADDR[15:0] == RTC_DATA_PORT) |=> !RTC_RW_STROBE_N && !ISA_OWNER_OE_N;
  endproperty
  a_rtc_rw: assert property (p_rtc_rw) else $error("rtc rw strobe missing");
  property p_rtc_ds;
    (ISA_BUS_OWN && CYC_IO_RD && CYC_ADDR[15:0] == RTC_DATA_PORT) |=> RTC_DATA_STROBE;
  endproperty
  a_rtc_ds: assert property (p_rtc_ds) else $error("rtc data strobe missing");
  property p_rom_sel;
    (ISA_BUS_OWN && rom_mem) |=> !ROM_RTC_SELECT_N;
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select missing");
  property p_rtc_sel;
    (ISA_BUS_OWN && CYC_IO_RD && CYC_ADDR[15:0] == RTC_ADDR_PORT) |=> !ROM_RTC_SELECT_N;
  endproperty
  a_rtc_sel: assert property (p_rtc_sel) else $error("rtc select missing");
  property p_kbd_sel;
    (ISA_BUS_OWN && io_cyc && CYC_ADDR[15:0] == KBD_CMD_PORT) |=> !KBD_SELECT_N;
  endproperty
  a_kbd_sel: assert property (p_kbd_sel) else $error("keyboard select missing");
  property p_ide_pass;
    !ISA_BUS_OWN |=> ISA_OWNER_OE_N && RTC_DATA_STROBE == $past(IDE_DD_OUT[12]);
  endproperty
  a_ide_pass: assert property (p_ide_pass) else $error("shared pin not handed to ide");
  property p_dack_stable;
    !mp.tick |=> $stable(ENCODED_DMA_ACK_OUT);
  endproperty
  a_dack_stable: assert property (p_dack_stable) else $error("ack code moved mid phase");
  property p_dack_idle;
    (mp.tick && !DMA_ACK_ACTIVE) |=> ENCODED_DMA_ACK_OUT == DACK_IDLE_CODE;
  endproperty
  a_dack_idle: assert property (p_dack_idle) else $error("idle code not shown");
  property p_dack_load;
    mp.tick |=> ENCODED_DMA_ACK_OUT == $past(dack_code);
  endproperty
  a_dack_load: assert property (p_dack_load) else $error("ack code not loaded at phase edge");
  property p_owner_isa;
    ISA_BUS_OWN |=> !ISA_OWNER_OE_N;
  endproperty
  a_owner_isa: assert property (p_owner_isa) else $error("ownership control not low for isa");

  c_rtc_write: cover property (CYC_IO_WR && ISA_BUS_OWN && CYC_ADDR[15:0] == RTC_DATA_PORT);
  c_dma_last: cover property (DMA_ACK_ACTIVE && DMA_LAST_XFER && mp.tick);
  c_phase_wrap: cover property (mp.tick && mp.phase == 2'h0);
  c_kbd_access: cover property (ISA_BUS_OWN && kbd_hit);
  c_ide_handover: cover property (!ISA_BUS_OWN && IDE_DD_OUT[12]);
endmodule : isa_sideband_decode

// file: tb/isa_glue_model.sv
`timescale 1ns/1ps
// outside glue: request encoders and acknowledge decoder, all combinational on the isa clocks
module isa_glue_model
  import isa_sideband_pkg::*;
(
  input wire logic isa_bus_clk,
  input wire logic isa_bus_clk_double,
  input wire logic [IRQ_CHANS-1:0] irq_lines,
  input wire logic [DREQ_CHANS-1:0] dreq_lines,
  input wire logic [2:0] encoded_dma_ack_out,
  input wire logic rom_rtc_select_n,
  input wire logic kbd_select_n,
  input wire logic rtc_rw_strobe_n,
  input wire logic rtc_data_strobe,
  input wire logic isa_owner_oe_n,
  output logic [IRQ_PINS-1:0] muxed_irq_in,
  output logic [DREQ_PINS-1:0] muxed_dma_req_in,
  output logic [DREQ_CHANS-1:0] dack_n,
  output logic [3:0] periph_sel_n
);
  wire logic [1:0] sel;
  // phase select seen by the encoders
  assign sel = {isa_bus_clk, isa_bus_clk_double};
  assign muxed_irq_in = irq_lines[sel*IRQ_PINS +: IRQ_PINS];
  assign muxed_dma_req_in = dreq_lines[sel*DREQ_PINS +: DREQ_PINS];
  // acknowledge decoded only while the doubled clock is high, so code changes never glitch
  assign dack_n = isa_bus_clk_double ? ~(8'h01 << encoded_dma_ack_out) : 8'hff;
  // selects masked by the ownership control while the ide side has the pins
  assign periph_sel_n = {rom_rtc_select_n, kbd_select_n, rtc_rw_strobe_n, rtc_data_strobe} | {4{isa_owner_oe_n}};
endmodule : isa_glue_model

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import isa_sideband_pkg::*;
  // short tick divider keeps a full phase rotation at a dozen cycles
  localparam int TDIV = 3;
  logic clk = 0, rst_n = 0, src_osc = 0, osc = 0, io_wr = 0, io_rd = 0, mem = 0;
  logic ack_act = 0, last = 0, own = 0;
  logic [19:0] addr = 20'h00000;
  logic [2:0] ack_chan = 3'h0;
  logic [3:0] ide_dd = 4'h0, m_irq, periph_n;
  logic [1:0] m_dreq, ph, pv;
  logic [15:0] irq_lines = 16'h0000, irq_req;
  logic [7:0] dreq_lines = 8'h00, dma_req;
  logic [2:0] enc_ack;
  logic bclk, bclk2, final_x, gp_n, as_n, rr_n, kb_n, rw_n, ds, oe_n;
  logic [31:0] rnd, rnd2;
  int errors = 0, comparisons = 0, seed = 51238, steps;
  logic [19:0] tbl [10] = '{20'h00070, 20'h00071, 20'h00060, 20'h00064, 20'h000e0,
                            20'he0000, 20'hfffff, 20'hdffff, 20'h00072, 20'h1006f};

  // clocks: core at 100 MHz, oscillator at 14.318 MHz with its own phase
  always #5 clk = ~clk;
  always #34.92 osc = ~osc;

  isa_sideband_decode #(.TICK_DIV(TDIV)) dut_u (
    .CORE_CLK(clk), .RESETN(rst_n), .CLK_SRC_OSC(src_osc), .OSC14M_IN(osc),
    .MUXED_IRQ_IN(m_irq), .MUXED_DMA_REQ_IN(m_dreq), .CYC_IO_WR(io_wr), .CYC_IO_RD(io_rd),
    .CYC_MEM(mem), .CYC_ADDR(addr), .DMA_ACK_ACTIVE(ack_act), .DMA_ACK_CHAN(ack_chan),
    .DMA_LAST_XFER(last), .ISA_BUS_OWN(own), .IDE_DD_OUT(ide_dd), .ISA_BUS_CLK(bclk),
    .ISA_BUS_CLK_DOUBLE(bclk2), .IRQ_REQ(irq_req), .DMA_REQ(dma_req), .ENCODED_DMA_ACK_OUT(enc_ack),
    .DMA_FINAL_TRANSFER(final_x), .GP_LATCH_STROBE_N(gp_n), .RTC_ADDR_STROBE_N(as_n),
    .ROM_RTC_SELECT_N(rr_n), .KBD_SELECT_N(kb_n), .RTC_RW_STROBE_N(rw_n),
    .RTC_DATA_STROBE(ds), .ISA_OWNER_OE_N(oe_n));

  isa_glue_model glue_u (
    .isa_bus_clk(bclk), .isa_bus_clk_double(bclk2), .irq_lines(irq_lines),
    .dreq_lines(dreq_lines), .encoded_dma_ack_out(enc_ack), .rom_rtc_select_n(rr_n),
    .kbd_select_n(kb_n), .rtc_rw_strobe_n(rw_n), .rtc_data_strobe(ds), .isa_owner_oe_n(oe_n),
    .muxed_irq_in(m_irq), .muxed_dma_req_in(m_dreq), .dack_n(), .periph_sel_n(periph_n));

  // expected {gp, as, rom/rtc, kbd, rw, ds, oe}; shared pins fall back to ide data
  function automatic logic [6:0] exp_dec(input logic w, r, m, input logic [19:0] a,
                                         input logic o, input logic [3:0] dd);
    logic [15:0] p;
    logic rr, kb;
    p = a[15:0];
    rr = (m && ((a & ROM_MASK) == ROM_BASE)) || ((w || r) && (p == RTC_ADDR_PORT || p == RTC_DATA_PORT));
    kb = (w || r) && (p == KBD_DATA_PORT || p == KBD_CMD_PORT);
    exp_dec[6] = !(w && p == GP_LATCH_PORT);
    exp_dec[5] = !(w && p == RTC_ADDR_PORT);
    exp_dec[4:1] = o ? {!rr, !kb, !(w && p == RTC_DATA_PORT), r && p == RTC_DATA_PORT} : dd;
    exp_dec[0] = !o;
  endfunction : exp_dec

  // one decoded cycle: kind 0 idle, 1 io write, 2 io read, 3 memory
  task automatic dec_cycle(input logic [1:0] k, input logic [19:0] a, input logic o);
    logic [6:0] e;
    @(negedge clk);
    rnd = $random(seed);
    io_wr = (k == 2'h1);
    io_rd = (k == 2'h2);
    mem = (k == 2'h3);
    addr = a;
    own = o;
    ide_dd = rnd[3:0];
    ack_act = rnd[4];
    last = rnd[5];
    @(negedge clk);
    e = exp_dec(io_wr, io_rd, mem, addr, own, ide_dd);
    `CHK("latch strobe", e[6], gp_n)
    `CHK("rtc strobes", {e[5], e[2:1]}, {as_n, rw_n, ds})
    `CHK("selects", e[4:3], {rr_n, kb_n})
    `CHK("owner oe", e[0], oe_n)
    `CHK("masked selects", e[0] ? 4'hf : e[4:1], periph_n)
    `CHK("final transfer", ack_act & last, final_x)
  endtask : dec_cycle

  // hold request lines long enough for two full rotations, then compare
  task automatic mux_check(input logic osc_mode);
    @(negedge clk);
    rnd = $random(seed);
    src_osc = osc_mode;
    irq_lines = rnd[15:0];
    dreq_lines = rnd[23:16];
    ack_act = rnd[24];
    ack_chan = rnd[27:25];
    repeat (60) @(negedge clk);
    `CHK("irq", irq_lines ^ (16'h0001 << RTC_IRQ_CHAN), irq_req)
    `CHK("dma req", dreq_lines, dma_req)
    `CHK("ack code", ack_act ? ack_chan : DACK_IDLE_CODE, enc_ack)
  endtask : mux_check

  task automatic print_verdict;
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // a hang costs a mismatch; the tests need about 1000 cycles
  initial begin
    #100000;
    errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    `CHK("reset outs", {2'h0, 16'h0000, 8'h00, 3'h4, 1'b0}, {bclk, bclk2, irq_req, dma_req, enc_ack, final_x})
    `CHK("reset strobes", 7'h7d, {gp_n, as_n, rr_n, kb_n, rw_n, ds, oe_n})
    rst_n = 1;
    // corner ports under every cycle kind, both owners
    for (int i = 0; i < 10; i++)
      for (int k = 0; k < 4; k++)
        for (int o = 0; o < 2; o++)
          dec_cycle(k[1:0], tbl[i], o[0]);
    for (int n = 0; n < 200; n++) begin
      rnd2 = $random(seed);
      dec_cycle(rnd2[1:0], rnd2[2] ? tbl[rnd2[6:3] % 10] : rnd2[31:12], rnd2[7]);
    end
    // phase steps once every TDIV cycles, in order
    pv = {bclk, bclk2};
    steps = 0;
    repeat (48) begin
      @(negedge clk);
      ph = {bclk, bclk2};
      if (ph !== pv) begin
        `CHK("phase order", pv + 2'h1, ph)
        steps++;
      end
      pv = ph;
    end
    `CHK("phase rate", 48 / TDIV, steps)
    for (int n = 0; n < 6; n++)
      mux_check(n[0]);
    print_verdict();
  end
endmodule : testbench
